//--- hw/pem_matrix.sv
// Top: event input matrix and six event-driven PWM engines
//
// Operation
// [RULE_01] Six engines, three inputs each, each with its own 2-bit selector.
// [RULE_02] Selector lines for engines 5..0 sit in writable selector registers.
// [RULE_03] Engine 0 routing table for inputs 0, 1, 2.
// [RULE_04] Engine 1 routing table for inputs 0, 1, 2.
// [RULE_05] Engine 2 routing table, input 1 code 11 is PWM 0.
// [RULE_06] Engine 3 routing table, input 1 code 11 is PWM 1.
// [RULE_07] Engine 4 routing table, input 1 code 11 is PWM 5.
// [RULE_08] Engine 5 routing table for inputs 0, 1, 2.
// [RULE_09] Six states: idle, four running, hold; events or timer advance.
// [RULE_10] Four 16-bit time registers per engine, one per running state.
// [RULE_11] Any transition may interrupt; eight request lines go out.
// [RULE_12] Six coupling schemes chosen by per-pair config and drive fields.
// [RULE_13] Native step about 10.4 ns, 1.3 ns effective with dithering.
// [RULE_14] Once set up, engines run without software, alone or grouped.
// [RULE_15] Selector is a four-way mux on synced sources, next cycle.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
module pem_matrix
  import pem_pkg::*;
(
  input wire logic clk, // engine clock
  input wire logic srst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state
  input wire logic [ADDR_W-1:0] addr, // register address
  input wire logic [DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [NUM_DIG-1:0] dig_in, // fast digital inputs
  input wire logic [NUM_CMP-1:0] cmp_in, // comparator outputs
  output logic [DATA_W-1:0] rdata, // read data, cycle after rd
  output logic [NUM_ENG-1:0] pwm_out, // engine outputs
  output logic [NUM_ENG-1:0] pwm_fine, // dithered outputs
  output logic [NUM_IRQ-1:0] irq_lines, // request lines
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------
  // Routing
  // ----------------------------------------------------------------
  // Source vector: [5:0] digital, [9:6] comparator, [15:10] software,
  // [21:16] engine outputs.
  localparam int SRC_W = 22;
  localparam int D0 = 0;
  localparam int C0 = 6;
  localparam int W0 = 10;
  localparam int P0 = 16;

  function automatic logic [4:0] route(input int e, input int i,
                                       input logic [1:0] s);
    int r;
    r = 0;
    unique case (e*3+i)
      0: r = (s==0)?C0+0:(s==1)?D0+0:(s==2)?D0+2:D0+5; // RULE_03
      1: r = (s==0)?C0+1:(s==1)?D0+0:(s==2)?D0+3:C0+3; // RULE_03
      2: r = (s==0)?C0+2:(s==1)?D0+1:(s==2)?D0+4:W0+0; // RULE_03
      3: r = (s==0)?C0+1:(s==1)?D0+1:(s==2)?D0+3:D0+0; // RULE_04
      4: r = (s==0)?C0+2:(s==1)?D0+1:(s==2)?D0+4:C0+3; // RULE_04
      5: r = (s==0)?C0+0:(s==1)?D0+2:(s==2)?D0+5:W0+1; // RULE_04
      6: r = (s==0)?C0+2:(s==1)?D0+2:(s==2)?D0+4:D0+1; // RULE_05
      7: r = (s==0)?C0+0:(s==1)?D0+2:(s==2)?D0+5:P0+0; // RULE_05
      8: r = (s==0)?C0+1:(s==1)?D0+3:(s==2)?D0+0:W0+2; // RULE_05
      9: r = (s==0)?C0+0:(s==1)?D0+3:(s==2)?D0+5:D0+2; // RULE_06
      10: r = (s==0)?C0+1:(s==1)?D0+3:(s==2)?D0+0:P0+1; // RULE_06
      11: r = (s==0)?C0+2:(s==1)?D0+4:(s==2)?D0+1:W0+3; // RULE_06
      12: r = (s==0)?C0+1:(s==1)?D0+4:(s==2)?D0+0:D0+3; // RULE_07
      13: r = (s==0)?C0+2:(s==1)?D0+4:(s==2)?D0+1:P0+5; // RULE_07
      14: r = (s==0)?C0+0:(s==1)?D0+5:(s==2)?D0+2:W0+4; // RULE_07
      15: r = (s==0)?C0+2:(s==1)?D0+5:(s==2)?D0+1:D0+4; // RULE_08
      16: r = (s==0)?C0+0:(s==1)?D0+5:(s==2)?D0+2:C0+3; // RULE_08
      default: r = (s==0)?C0+1:(s==1)?D0+0:(s==2)?D0+3:W0+5; // RULE_08
    endcase
    return r[4:0];
  endfunction : route

  function automatic logic [4:0] time_idx(input int e, input int st);
    int t;
    t = e*4 + st;
    return t[4:0];
  endfunction : time_idx

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] pin_s1_q, pin_s2_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (ce) begin
      pin_s1_q <= {cmp_in, dig_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] sel_q [NUM_ENG], sel_d [NUM_ENG];
  logic [15:0] ctrl_q [NUM_ENG], ctrl_d [NUM_ENG];
  logic [3:0] pair_q [3], pair_d [3];
  logic [5:0] swev_q, swev_d;
  logic [5:0] stat_q, stat_d, ien_q, ien_d;
  logic [15:0] rdata_q, rdata_d;
  logic rd_time_q, rd_time_d;

  pem_time_if tif ();
  pem_time_mem u_mem (.clk(clk), .ce(ce), .bus(tif.mem));

  // ----------------------------------------------------------------
  // Engines
  // ----------------------------------------------------------------
  pem_state_t st_q [NUM_ENG], st_d [NUM_ENG];
  logic [15:0] cnt_q [NUM_ENG], cnt_d [NUM_ENG];
  logic [15:0] lim_q [NUM_ENG], lim_d [NUM_ENG];
  logic [2:0] ev_q [NUM_ENG], ev_d [NUM_ENG];
  logic [2:0] dph_q [NUM_ENG], dph_d [NUM_ENG];
  logic [NUM_ENG-1:0] lvl_q, lvl_d, fine_q, fine_d, trans;
  logic [2:0] ld_eng_q, ld_eng_d;
  logic [2:0] ld_prv_q, ld_prv_d;
  logic ld_ok_q, ld_ok_d;
  logic [SRC_W-1:0] src;
  logic [NUM_IRQ-1:0] irql_q, irql_d;
  logic irq_q, irq_d;

  assign src = {lvl_q, swev_q, pin_s2_q};

  always_comb begin
    int e, i, k;
    logic adv;
    e = 0;
    i = 0;
    k = 0;
    adv = 1'b0;
    swev_d = '0; // Software events are one-cycle pulses
    stat_d = stat_q;
    ien_d = ien_q;
    rd_time_d = 1'b0;
    rdata_d = '0;
    tif.we = 1'b0;
    tif.waddr = '0;
    tif.wdata = wdata;
    // Time memory read port cycles through engines to reload limits,
    // shared with software reads so no extra port is needed.
    ld_eng_d = (ld_eng_q == 3'(NUM_ENG-1)) ? 3'h0 : ld_eng_q + 3'h1;
    ld_prv_d = ld_eng_q;
    tif.raddr = '0;
    for (e = 0; e < NUM_ENG; e++) begin
      sel_d[e] = sel_q[e];
      ctrl_d[e] = ctrl_q[e];
    end
    for (k = 0; k < 3; k++) begin
      pair_d[k] = pair_q[k];
    end
    if (wr) begin
      if (addr < OFS_SEL_BASE + 8'(NUM_ENG)) begin
        sel_d[addr[2:0]] = wdata[5:0]; // RULE_02
      end else if (addr >= OFS_CTRL_BASE &&
                   addr < OFS_CTRL_BASE + 8'(NUM_ENG)) begin
        ctrl_d[addr[2:0]] = wdata;
      end else if (addr >= OFS_PAIR_BASE && addr < OFS_PAIR_BASE + 8'h3) begin
        pair_d[addr[1:0]] = wdata[3:0]; // RULE_12
      end else if (addr == OFS_SWEV) begin
        swev_d = wdata[5:0];
      end else if (addr == OFS_IRQ_EN) begin
        ien_d = wdata[5:0];
      end else if (addr == OFS_IRQ_CLR) begin
        stat_d = stat_q & ~wdata[5:0];
      end else if (addr >= OFS_TIME_BASE &&
                   addr < OFS_TIME_BASE + 8'(NUM_ENG*4)) begin
        tif.we = 1'b1; // RULE_10
        tif.waddr = 5'(addr - OFS_TIME_BASE);
      end
    end
    if (rd) begin
      if (addr < OFS_SEL_BASE + 8'(NUM_ENG)) begin
        rdata_d = {10'h000, sel_q[addr[2:0]]};
      end else if (addr >= OFS_CTRL_BASE &&
                   addr < OFS_CTRL_BASE + 8'(NUM_ENG)) begin
        rdata_d = ctrl_q[addr[2:0]];
      end else if (addr >= OFS_PAIR_BASE && addr < OFS_PAIR_BASE + 8'h3) begin
        rdata_d = {12'h000, pair_q[addr[1:0]]};
      end else if (addr == OFS_IRQ_STAT) begin
        rdata_d = {10'h000, stat_q};
      end else if (addr == OFS_IRQ_EN) begin
        rdata_d = {10'h000, ien_q};
      end else if (addr >= OFS_STATE_BASE &&
                   addr < OFS_STATE_BASE + 8'(NUM_ENG)) begin
        rdata_d = {10'h000, st_q[addr[2:0]]};
      end else if (addr >= OFS_TIME_BASE &&
                   addr < OFS_TIME_BASE + 8'(NUM_ENG*4)) begin
        tif.raddr = 5'(addr - OFS_TIME_BASE);
        rd_time_d = 1'b1;
        ld_eng_d = ld_eng_q; // Reload slot held; same engine retried next cycle
      end
    end
    if (!rd_time_d) begin
      tif.raddr = time_idx(int'(ld_eng_q), 0) | 5'(st_q[ld_eng_q][2] ? 1 :
                  st_q[ld_eng_q][3] ? 2 : st_q[ld_eng_q][4] ? 3 : 0);
    end
    for (e = 0; e < NUM_ENG; e++) begin
      st_d[e] = st_q[e];
      lim_d[e] = lim_q[e];
      lvl_d[e] = lvl_q[e];
      cnt_d[e] = cnt_q[e];
      trans[e] = 1'b0;
      for (i = 0; i < NUM_IN; i++) begin
        ev_d[e][i] = src[route(e, i, sel_q[e][2*i +: 2])]; // RULE_15 RULE_01
      end
      adv = |(ev_q[e] & ctrl_q[e][CTL_NXT_LSB +: 3]) ||
            (cnt_q[e] >= lim_q[e]); // RULE_09
      unique case (st_q[e])
        PEM_IDLE: if (ctrl_q[e][CTL_RUN]) begin
          st_d[e] = PEM_S0;
          trans[e] = 1'b1;
        end
        PEM_S0, PEM_S1, PEM_S2, PEM_S3: begin
          if (!ctrl_q[e][CTL_RUN]) begin
            st_d[e] = PEM_IDLE;
            trans[e] = 1'b1;
          end else if (ctrl_q[e][CTL_HOLD]) begin
            st_d[e] = PEM_HOLD;
            trans[e] = 1'b1;
          end else if (adv) begin // RULE_14
            st_d[e] = (st_q[e] == PEM_S3) ? PEM_S0 :
                      pem_state_t'({st_q[e][4:0], 1'b0});
            trans[e] = 1'b1;
          end
        end
        PEM_HOLD: if (!ctrl_q[e][CTL_HOLD] || !ctrl_q[e][CTL_RUN]) begin
          st_d[e] = ctrl_q[e][CTL_RUN] ? PEM_S0 : PEM_IDLE;
          trans[e] = 1'b1;
        end
        default: begin
          st_d[e] = PEM_IDLE;
          trans[e] = 1'b1;
        end
      endcase
      cnt_d[e] = trans[e] ? 16'h0000 :
                 (st_q[e][4:1] != 4'h0) ? cnt_q[e] + 16'h0001 : cnt_q[e];
      if (ld_prv_q == 3'(e) && ld_ok_q && !trans[e]) begin
        lim_d[e] = tif.rdata; // RULE_10
      end
      lvl_d[e] = (st_d[e][4:1] != 4'h0) &&
                 |(ctrl_q[e][CTL_LVL_LSB +: 4] & st_d[e][4:1]);
      // Dither: a running phase accumulator stretches the edge by 1.3 ns
      // units on the fine output; native output stays on the step grid.
      dph_d[e] = ctrl_q[e][CTL_DITHER] ? 3'(dph_q[e] + 3'(DITH_PH-1))
                                        : 3'h0; // RULE_13
      fine_d[e] = lvl_q[e] | (lvl_d[e] & ctrl_q[e][CTL_DITHER] &
                  (dph_q[e] == 3'h0));
      stat_d[e] = stat_d[e] | trans[e]; // RULE_11
    end
    // Reload data come back a cycle late: keep them only for the engine
    // that asked, and only if its state did not move in between.
    ld_ok_d = !rd_time_d && !trans[ld_eng_q];
    // Coupling: pair k merges engine 2k+1 onto engine 2k when drive set and config is not single
    for (k = 0; k < 3; k++) begin
      if (pair_q[k][PAIR_DRV] && pair_q[k][2:0] != PEM_CFG_SINGLE) begin
        lvl_d[2*k] = lvl_d[2*k] | lvl_d[2*k+1]; // RULE_12
      end
      if (pair_q[k][2:0] == PEM_CFG_SYNC || pair_q[k][2:0] == PEM_CFG_SYNC2) begin
        if (trans[2*k] && st_d[2*k] == PEM_S0) begin
          cnt_d[2*k+1] = 16'h0000; // RULE_12
        end
      end
    end
    irql_d = {ien_q[5:4] != 2'b00, |ien_q, stat_d & ien_q}; // RULE_11
    irq_d = |(stat_d & ien_q);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int n = 0; n < NUM_ENG; n++) begin
        sel_q[n] <= SEL_RST;
        ctrl_q[n] <= CTRL_RST;
        st_q[n] <= PEM_IDLE;
        cnt_q[n] <= '0;
        lim_q[n] <= TIME_RST;
        ev_q[n] <= '0;
        dph_q[n] <= '0;
      end
      for (int n = 0; n < 3; n++) begin
        pair_q[n] <= '0;
      end
      swev_q <= '0;
      stat_q <= '0;
      ien_q <= '0;
      rdata_q <= '0;
      rd_time_q <= 1'b0;
      lvl_q <= '0;
      fine_q <= '0;
      ld_eng_q <= '0;
      ld_prv_q <= '0;
      ld_ok_q <= 1'b0;
      irql_q <= '0;
      irq_q <= 1'b0;
    end else if (ce) begin
      sel_q <= sel_d;
      ctrl_q <= ctrl_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      lim_q <= lim_d;
      ev_q <= ev_d;
      dph_q <= dph_d;
      pair_q <= pair_d;
      swev_q <= swev_d;
      stat_q <= stat_d;
      ien_q <= ien_d;
      rdata_q <= rdata_d;
      rd_time_q <= rd_time_d;
      lvl_q <= lvl_d;
      fine_q <= fine_d;
      ld_eng_q <= ld_eng_d;
      ld_prv_q <= ld_prv_d;
      ld_ok_q <= ld_ok_d;
      irql_q <= irql_d;
      irq_q <= irq_d;
    end
  end

  // Time reads return from the memory register, others from rdata_q
  assign rdata = rd_time_q ? tif.rdata : rdata_q;
  assign pwm_out = lvl_q;
  assign pwm_fine = fine_q;
  assign irq_lines = irql_q;
  assign irq = irq_q;

endmodule : pem_matrix

//--- pkg/pem_pkg.sv
// Package: constants and types for the PWM engine event matrix
package pem_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_ENG = 6;
  localparam int NUM_IN = 3;
  localparam int NUM_DIG = 6;
  localparam int NUM_CMP = 4;
  localparam int TIME_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_IRQ = 8;

  // ----------------------------------------------------------------
  // Register offsets (word index on the plain port)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SEL_BASE = 8'h00; // one per engine, 0..5
  localparam logic [7:0] OFS_CTRL_BASE = 8'h08; // one per engine
  localparam logic [7:0] OFS_PAIR_BASE = 8'h10; // one per engine pair
  localparam logic [7:0] OFS_SWEV = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h15;
  localparam logic [7:0] OFS_IRQ_EN = 8'h16;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h17;
  localparam logic [7:0] OFS_STATE_BASE = 8'h18; // read-only state
  localparam logic [7:0] OFS_TIME_BASE = 8'h20; // engine*4 + state

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTL_RUN = 0;
  localparam int CTL_HOLD = 1;
  localparam int CTL_DITHER = 2;
  localparam int CTL_LVL_LSB = 4; // output level per running state, 4 bits
  localparam int CTL_NXT_LSB = 8; // event input 0..2 -> advance enable
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] TIME_RST = 16'hffff;
  localparam logic [5:0] SEL_RST = 6'h00;

  // Pair config: [2:0] global config, [3] merged output drive
  localparam int PAIR_DRV = 3;

  // Native step 10.4 ns, dithering reaches 1.3 ns: 8 phases
  localparam int STEP_PS = 10400;
  localparam int DITH_PS = 1300;
  localparam int DITH_PH = STEP_PS / DITH_PS;

  typedef enum logic [5:0] {
    PEM_IDLE = 6'b000001,
    PEM_S0 = 6'b000010,
    PEM_S1 = 6'b000100,
    PEM_S2 = 6'b001000,
    PEM_S3 = 6'b010000,
    PEM_HOLD = 6'b100000
  } pem_state_t;

  typedef enum logic [2:0] {
    PEM_CFG_SINGLE = 3'h0,
    PEM_CFG_SYNC = 3'h1,
    PEM_CFG_ASYNC = 3'h2,
    PEM_CFG_SYNC2 = 3'h3,
    PEM_CFG_ASYNC2 = 3'h4,
    PEM_CFG_EXT = 3'h5
  } pem_couple_t;

endpackage : pem_pkg

//--- pkg/pem_time_if.sv
// Interface: time register memory access between top and memory
`timescale 1ns/1ns
interface pem_time_if;
  logic we;
  logic [4:0] waddr;
  logic [15:0] wdata;
  logic [4:0] raddr;
  logic [15:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr,
               input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface : pem_time_if

//--- hw/pem_time_mem.sv
// Memory: per-engine, per-state 16-bit time registers
`timescale 1ns/1ns
module pem_time_mem
  import pem_pkg::*;
(
  input wire logic clk, // clock
  input wire logic ce, // clock enable
  pem_time_if.mem bus // write and read port
);

  logic [TIME_W-1:0] mem_q [0:NUM_ENG*4-1];
  logic [TIME_W-1:0] rd_q;

  always_ff @(posedge clk) begin
    if (ce) begin
      if (bus.we) begin
        mem_q[bus.waddr] <= bus.wdata;
      end
      rd_q <= mem_q[bus.raddr];
    end
  end

  assign bus.rdata = rd_q;

endmodule : pem_time_mem

//--- dv/pem_event_src.sv
// Partner: model of the external comparators and fast digital inputs
`timescale 1ns/1ns
module pem_event_src
  import pem_pkg::*;
(
  input wire logic clk, // engine clock
  input wire logic [NUM_DIG-1:0] dig_req, // one-cycle pulse request
  input wire logic [NUM_CMP-1:0] cmp_req, // one-cycle pulse request
  output logic [NUM_DIG-1:0] dig_in, // digital input levels
  output logic [NUM_CMP-1:0] cmp_in // comparator output levels
);
  initial begin
    dig_in = '0;
    cmp_in = '0;
  end

  // Lines move just after an edge, so the synchroniser sees clean levels
  always @(posedge clk) begin
    dig_in <= dig_req;
    cmp_in <= cmp_req;
  end
endmodule : pem_event_src

//--- dv/pem_matrix_properties.sv
// Checker: port-level properties of the event matrix top
`timescale 1ns/1ns
module pem_matrix_props
  import pem_pkg::*;
(
  input wire logic clk, // engine clock
  input wire logic srst, // synchronous reset
  input wire logic ce, // clock enable
  input wire logic [ADDR_W-1:0] addr, // register address
  input wire logic [DATA_W-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [NUM_DIG-1:0] dig_in, // digital inputs
  input wire logic [NUM_CMP-1:0] cmp_in, // comparator outputs
  input wire logic [DATA_W-1:0] rdata, // read data
  input wire logic [NUM_ENG-1:0] pwm_out, // engine outputs
  input wire logic [NUM_ENG-1:0] pwm_fine, // dithered outputs
  input wire logic [NUM_IRQ-1:0] irq_lines, // request lines
  input wire logic irq // level interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // Bus steps
  // ----------------------------------------------------------------
  sequence s_rd_state;
    rd && ce && addr >= OFS_STATE_BASE && addr <= 8'h1d;
  endsequence
  sequence s_en_wr;
    wr && ce && addr == OFS_IRQ_EN;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_rd_quiet: assert property (ce && !rd |=> rdata == '0)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd && ce && addr > 8'h37 |=> rdata == '0)
    else $error("unmapped read returned data");
  a_sel_narrow: assert property (rd && ce && addr <= 8'h05 |=> rdata[15:6] == '0)
    else $error("selector read wider than three fields");
  a_state_onehot: assert property (s_rd_state |=> $onehot(rdata[5:0]) && rdata[15:6] == '0)
    else $error("engine state not one of six");
  a_irq_level: assert property (irq == |irq_lines[5:0])
    else $error("interrupt level disagrees with lines");
  a_en_any: assert property (s_en_wr |-> ##2 irq_lines[6] == $past(|wdata[5:0], 2))
    else $error("any-enable line wrong");
  a_en_upper: assert property (s_en_wr |-> ##2 irq_lines[7] == $past(|wdata[5:4], 2))
    else $error("upper-enable line wrong");
  a_en_off: assert property (s_en_wr ##0 wdata[5:0] == '0 |-> ##2 irq_lines[5:0] == '0)
    else $error("masked engine still requests");
  a_reset_quiet: assert property ($fell(srst) |-> pwm_out == '0 && irq_lines == '0 && !irq)
    else $error("outputs active after reset");
  a_ce_freeze: assert property (
    !ce |=> $stable({rdata, pwm_out, pwm_fine, irq_lines, irq}))
    else $error("outputs moved while clock enable low");
endmodule : pem_matrix_props

bind pem_matrix pem_matrix_props u_pem_matrix_props (.clk(clk), .srst(srst),
  .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .dig_in(dig_in),
  .cmp_in(cmp_in), .rdata(rdata), .pwm_out(pwm_out), .pwm_fine(pwm_fine),
  .irq_lines(irq_lines), .irq(irq));

//--- dv/test_pwm_engine_event_input_matrix.sv
// Testbench: routing sweep, registers, interrupts and engine states
`timescale 1ns/1ns
module test_pwm_engine_event_input_matrix;
  import pem_pkg::*;
  logic clk, srst, ce, wr, rd;
  logic [7:0] addr, irq_lines;
  logic [15:0] wdata, rdata, got;
  logic [5:0] pwm_out, pwm_fine, dig_in, dig_req;
  logic [3:0] cmp_in, cmp_req;
  logic irq;
  int errors, total_checks;
  // Rows per engine input: sources for codes 11,10,01,00
  // Source byte: 0n comparator, 1n digital, 2n software, 3n engine output
  logic [31:0] route_tbl [18] = '{
    32'h15121000, 32'h03131001, 32'h20141102,
    32'h10131101, 32'h03141102, 32'h21151200,
    32'h11141202, 32'h30151200, 32'h22101301,
    32'h12151300, 32'h31101301, 32'h23111402,
    32'h13101401, 32'h35111402, 32'h24121500,
    32'h14111502, 32'h03121500, 32'h25131001};

  pem_matrix u_pem_matrix (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .dig_in(dig_in), .cmp_in(cmp_in),
    .rdata(rdata), .pwm_out(pwm_out), .pwm_fine(pwm_fine),
    .irq_lines(irq_lines), .irq(irq));
  pem_event_src u_pem_event_src (.clk(clk), .dig_req(dig_req),
    .cmp_req(cmp_req), .dig_in(dig_in), .cmp_in(cmp_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(logic [15:0] exp, logic [15:0] act);
    total_checks++;
    if (act !== exp) begin
      errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic bus_wr(logic [7:0] a, logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus_wr

  // Two writes to one place with no gap, for a one-cycle engine output
  task automatic bus_wr2(logic [7:0] a, logic [15:0] d1, logic [15:0] d2);
    addr <= a;
    wdata <= d1;
    wr <= 1'b1;
    @(posedge clk);
    wdata <= d2;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus_wr2

  task automatic rc(logic [7:0] a, logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
    chk(exp, got);
    @(posedge clk);
  endtask : rc

  task automatic pulse(logic [7:0] s);
    case (s[7:4])
      4'h0: begin
        cmp_req <= 4'h1 << s[1:0];
        @(posedge clk);
        cmp_req <= '0;
      end
      4'h1: begin
        dig_req <= 6'h01 << s[2:0];
        @(posedge clk);
        dig_req <= '0;
      end
      4'h2: bus_wr(OFS_SWEV, 16'h0001 << s[2:0]);
      default: bus_wr2(OFS_CTRL_BASE + {4'h0, s[3:0]}, 16'h0011, 16'h0000);
    endcase
  endtask : pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    dig_req = '0;
    cmp_req = '0;
    errors = 0;
    total_checks = 0;
    cyc(16);
    srst <= 1'b0;
    @(posedge clk);
    for (int e = 0; e < NUM_ENG; e++) begin
      rc(OFS_SEL_BASE + 8'(e), 16'(SEL_RST));
      rc(OFS_CTRL_BASE + 8'(e), CTRL_RST);
      rc(OFS_STATE_BASE + 8'(e), 16'(PEM_IDLE));
    end
    // Time memory is not reset, so load idle limits before running
    for (int t = 0; t < 24; t++) bus_wr(OFS_TIME_BASE + 8'(t), TIME_RST);
    for (int r = 0; r < 72; r++) begin
      int e, i, c;
      e = r / 12;
      i = (r / 4) % 3;
      c = r % 4;
      bus_wr(OFS_SEL_BASE + 8'(e), 16'(c << (2 * i)));
      bus_wr(OFS_CTRL_BASE + 8'(e), 16'h0001 | (16'h0100 << i));
      cyc(4);
      rc(OFS_STATE_BASE + 8'(e), 16'(PEM_S0));
      pulse(route_tbl[e * 3 + i][8 * c +: 8]);
      cyc(6);
      rc(OFS_STATE_BASE + 8'(e), 16'(PEM_S1));
      bus_wr(OFS_CTRL_BASE + 8'(e), 16'h0000);
    end
    rc(OFS_IRQ_STAT, 16'h003f);
    bus_wr(OFS_IRQ_EN, 16'h003f);
    cyc(2);
    #1 chk(16'h00ff, 16'(irq_lines));
    chk(16'h0001, 16'(irq));
    bus_wr(OFS_IRQ_EN, 16'h000f);
    cyc(2);
    #1 chk(16'h004f, 16'(irq_lines));
    bus_wr(OFS_IRQ_CLR, 16'h003f);
    cyc(2);
    #1 chk(16'h0040, 16'(irq_lines));
    chk(16'h0000, 16'(irq));
    rc(OFS_IRQ_EN, 16'h000f);
    bus_wr(OFS_IRQ_EN, 16'h0000);
    bus_wr(OFS_CTRL_BASE, 16'h0003);
    cyc(3);
    rc(OFS_STATE_BASE, 16'(PEM_HOLD));
    bus_wr(OFS_CTRL_BASE, 16'h0000);
    cyc(3);
    rc(OFS_STATE_BASE, 16'(PEM_IDLE));
    // Engine 1 gets short limits, engine 2 keeps the idle ones
    for (int s = 4; s < 8; s++) bus_wr(OFS_TIME_BASE + 8'(s), 16'h0004);
    rc(OFS_TIME_BASE + 8'h04, 16'h0004);
    bus_wr(OFS_CTRL_BASE + 8'h01, 16'h0001);
    bus_wr(OFS_CTRL_BASE + 8'h02, 16'h0001);
    cyc(4);
    bus_wr(OFS_IRQ_CLR, 16'h003f);
    cyc(40);
    rc(OFS_IRQ_STAT, 16'h0002);
    bus_wr(OFS_CTRL_BASE + 8'h01, 16'h0000);
    bus_wr(OFS_CTRL_BASE + 8'h02, 16'h0000);
    // Steady S0 level on engine 0, then engine 1 merged onto output 0
    bus_wr(OFS_CTRL_BASE, 16'h0015);
    cyc(3);
    #1 chk(16'h0001, 16'(pwm_out));
    chk(16'h0001, 16'(pwm_fine));
    bus_wr(OFS_PAIR_BASE, 16'h0009);
    bus_wr(OFS_CTRL_BASE, 16'h0000);
    bus_wr(OFS_CTRL_BASE + 8'h01, 16'h00f1);
    cyc(3);
    #1 chk(16'h0003, 16'(pwm_out));
    bus_wr(OFS_CTRL_BASE + 8'h01, 16'h0000);
    bus_wr(OFS_PAIR_BASE, 16'h0000);
    cyc(2);
    bus_wr(OFS_IRQ_CLR, 16'h003f);
    bus_wr(OFS_IRQ_STAT, 16'hffff);
    rc(OFS_IRQ_STAT, 16'h0000);
    rc(8'h06, 16'h0000);
    rc(8'hff, 16'h0000);
    bus_wr(OFS_SEL_BASE + 8'h05, 16'h0039);
    rc(OFS_SEL_BASE + 8'h05, 16'h0039);
    // A write while the clock enable is low must leave no trace
    ce <= 1'b0;
    bus_wr(OFS_SEL_BASE + 8'h05, 16'h0000);
    ce <= 1'b1;
    rc(OFS_SEL_BASE + 8'h05, 16'h0039);
    srst <= 1'b1;
    cyc(3);
    srst <= 1'b0;
    @(posedge clk);
    rc(OFS_SEL_BASE + 8'h05, 16'(SEL_RST));
    test_done();
  end
endmodule : test_pwm_engine_event_input_matrix
